/* hdl/lsec_config_bank.sv */
// Lane equalizer, emphasis and swing register bank with decoded lane drive outputs
// Overview of operation
// - Clock-lane EQ level applied only in HDMI 2.1
// - Each data lane has 4-bit EQ level
// - Data lanes have 3-bit emphasis, fixed dB table
// - Limited swing codes trim around 1000 mV
// - Linear swing codes 800 to 1200 mV
// - Emphasis and swing registers reset to 03h
// - Equalizer registers reset to 00h
// - Clock-lane emphasis applied only in HDMI 2.1
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
module lsec_config_bank (
  input wire logic clk, // 250 MHz clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic [lsec_pkg::ADDR_W-1:0] addr, // Register address
  input wire logic [lsec_pkg::DATA_W-1:0] wr_data, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  input wire logic hdmi21_mode, // High while the link runs fixed-rate HDMI 2.1
  input wire logic linear_mode, // High for linear, low for limited redriver
  output logic [lsec_pkg::DATA_W-1:0] rd_data_q, // Read data, cycle after rd_en
  output logic [3:0] clock_lane_eq_level_q, // Applied clock-lane EQ level
  output logic signed [7:0] clock_lane_emphasis_q, // Applied clock-lane emphasis, 0.1 dB
  output lsec_pkg::lsec_lane_drive_s [lsec_pkg::LANES-1:0] lane_drive_q // Data lane drive
);
  localparam int NREG = lsec_pkg::LANES + 1;

  // Address decode shared by the write and read paths
  function automatic lsec_pkg::lsec_decode_s decode_addr(input logic [7:0] a);
    lsec_pkg::lsec_decode_s d;
    d = '0;
    unique case (a)
      lsec_pkg::CLOCK_LANE_EMPHASIS_OFS: d = '{hit: 1'b1, is_eq: 1'b0, idx: 2'h0};
      lsec_pkg::CLOCK_LANE_EQUALIZER_OFS: d = '{hit: 1'b1, is_eq: 1'b1, idx: 2'h0};
      lsec_pkg::LANE0_EMPHASIS_SWING_OFS: d = '{hit: 1'b1, is_eq: 1'b0, idx: 2'h1};
      lsec_pkg::LANE0_EQUALIZER_OFS: d = '{hit: 1'b1, is_eq: 1'b1, idx: 2'h1};
      lsec_pkg::LANE1_EMPHASIS_SWING_OFS: d = '{hit: 1'b1, is_eq: 1'b0, idx: 2'h2};
      lsec_pkg::LANE1_EQUALIZER_OFS: d = '{hit: 1'b1, is_eq: 1'b1, idx: 2'h2};
      lsec_pkg::LANE2_EMPHASIS_SWING_OFS: d = '{hit: 1'b1, is_eq: 1'b0, idx: 2'h3};
      lsec_pkg::LANE2_EQUALIZER_OFS: d = '{hit: 1'b1, is_eq: 1'b1, idx: 2'h3};
      default: d = '0;
    endcase
    return d;
  endfunction : decode_addr

  // Reset release through two flops
  logic rst_meta_q;
  logic rst_sync_n_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n_q <= rst_meta_q;
    end
  end

  // Register storage, index 0 is the clock lane, 1..3 the data lanes
  logic [7:0] eq_q [NREG];
  logic [7:0] eq_d [NREG];
  logic [7:0] es_q [NREG];
  logic [7:0] es_d [NREG];
  logic [7:0] rd_data_d;
  lsec_pkg::lsec_decode_s wdec;
  lsec_pkg::lsec_decode_s rdec;

  always_comb begin
    wdec = decode_addr(addr);
    rdec = decode_addr(addr);
    for (int i = 0; i < NREG; i++) begin
      eq_d[i] = eq_q[i];
      es_d[i] = es_q[i];
    end
    if (wr_en && wdec.hit) begin
      if (wdec.is_eq) begin
        eq_d[wdec.idx] = wr_data & lsec_pkg::EQ_MASK;
      end else begin
        es_d[wdec.idx] = wr_data & lsec_pkg::EMPH_SWING_MASK;
      end
    end
    rd_data_d = '0;
    if (rd_en && rdec.hit) begin
      rd_data_d = rdec.is_eq ? eq_q[rdec.idx] : es_q[rdec.idx];
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      for (int i = 0; i < NREG; i++) begin
        eq_q[i] <= lsec_pkg::EQ_RESET;
        es_q[i] <= lsec_pkg::EMPH_SWING_RESET;
      end
      rd_data_q <= '0;
    end else begin
      for (int i = 0; i < NREG; i++) begin
        eq_q[i] <= eq_d[i];
        es_q[i] <= es_d[i];
      end
      rd_data_q <= rd_data_d;
    end
  end

  // Lane decoding
  lsec_pkg::lsec_lane_drive_s drive_w [NREG];
  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_lane
      lsec_pkg::lsec_lane_cfg_s cfg_w;
      assign cfg_w.eq_level = eq_q[g][lsec_pkg::EQ_LSB +: lsec_pkg::EQ_W];
      assign cfg_w.emphasis = es_q[g][lsec_pkg::EMPH_LSB +: lsec_pkg::EMPH_W];
      assign cfg_w.swing = es_q[g][lsec_pkg::SWING_LSB +: lsec_pkg::SWING_W];
      lsec_lane_decode u_dec (
        .cfg(cfg_w),
        .linear_mode(linear_mode),
        .drive(drive_w[g])
      );
    end
  endgenerate

  // Applied drive values
  logic [3:0] clock_eq_d;
  logic signed [7:0] clk_emph_d;
  lsec_pkg::lsec_lane_drive_s [lsec_pkg::LANES-1:0] lane_drive_d;
  always_comb begin
    // Clock-lane fields are held at their neutral value outside HDMI 2.1
    clock_eq_d = hdmi21_mode ? drive_w[0].eq_level : 4'h0;
    clk_emph_d = hdmi21_mode ? drive_w[0].emph_db10 : 8'sh00;
    for (int i = 0; i < lsec_pkg::LANES; i++) begin
      lane_drive_d[i] = drive_w[i+1];
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      clock_lane_eq_level_q <= '0;
      clock_lane_emphasis_q <= '0;
      lane_drive_q <= '0;
    end else begin
      clock_lane_eq_level_q <= clock_eq_d;
      clock_lane_emphasis_q <= clk_emph_d;
      lane_drive_q <= lane_drive_d;
    end
  end

  // Checks
  clock_eq_gate_a: assert property (
    @(posedge clk) disable iff (!rst_sync_n_q)
    !hdmi21_mode |=> clock_lane_eq_level_q == 4'h0)
    else $error("clock lane eq applied outside hdmi 2.1");

  eq_readback_a: assert property (
    @(posedge clk) disable iff (!rst_sync_n_q)
    (wr_en && addr == lsec_pkg::LANE0_EQUALIZER_OFS) ##1
      (rd_en && addr == lsec_pkg::LANE0_EQUALIZER_OFS && !wr_en)
    |=> rd_data_q == {4'h0, $past(wr_data[3:0], 2)})
    else $error("lane0 eq readback mismatch");

  emph_map_a: assert property (
    @(posedge clk) disable iff (!rst_sync_n_q)
    es_q[1][6:4] == 3'h7 |=> lane_drive_q[0].emph_db10 == -8'sh30)
    else $error("lane0 emphasis code 7 not -4.8 dB");

  rsvd_emph_a: assert property (
    @(posedge clk) disable iff (!rst_sync_n_q)
    es_q[2][6:4] == 3'h3 |=> lane_drive_q[1].code_reserved)
    else $error("reserved emphasis code not flagged");

  swing_limited_a: assert property (
    @(posedge clk) disable iff (!rst_sync_n_q)
    (!linear_mode && es_q[3][2:0] == 3'h0) |=> lane_drive_q[2].swing_mv == 11'h352)
    else $error("limited swing code 0 not 850 mV");

  swing_linear_a: assert property (
    @(posedge clk) disable iff (!rst_sync_n_q)
    (linear_mode && es_q[1][2:0] == 3'h3) |=> lane_drive_q[0].swing_mv == 11'h4B0)
    else $error("linear swing code 3 not 1200 mV");

  reset_values_a: assert property (
    @(posedge clk) $rose(rst_sync_n_q) |->
      es_q[0] == 8'h03 && es_q[1] == 8'h03 && es_q[2] == 8'h03 && es_q[3] == 8'h03)
    else $error("emphasis swing reset value wrong");

  eq_reset_a: assert property (
    @(posedge clk) $rose(rst_sync_n_q) |->
      eq_q[0] == 8'h00 && eq_q[1] == 8'h00 && eq_q[2] == 8'h00 && eq_q[3] == 8'h00)
    else $error("equalizer reset value wrong");

  rsvd_bits_a: assert property (
    @(posedge clk) disable iff (!rst_sync_n_q)
    $past(rd_en) |-> rd_data_q[7] == 1'b0 &&
      ($past(rdec.is_eq) ? rd_data_q[6:4] == 3'h0 : rd_data_q[3] == 1'b0))
    else $error("reserved bits read nonzero");

  clk_emph_gate_a: assert property (
    @(posedge clk) disable iff (!rst_sync_n_q)
    hdmi21_mode |=> clock_lane_emphasis_q == $past(drive_w[0].emph_db10))
    else $error("clock lane emphasis not applied in hdmi 2.1");

  // Mode-gate, follow, fixed-code, mask, write and read checks on the decoded drive values and the register path
  clock_eq_on_a: assert property (
    @(posedge clk) disable iff (!rst_sync_n_q)
    hdmi21_mode |=> clock_lane_eq_level_q == $past(eq_q[0][3:0]))
    else $error("clock lane eq not applied in hdmi 2.1");

  clock_emph_off_a: assert property (
    @(posedge clk) disable iff (!rst_sync_n_q)
    !hdmi21_mode |=> clock_lane_emphasis_q == 8'sh00)
    else $error("clock lane emphasis applied outside hdmi 2.1");

  lane_eq_follow_a: assert property (
    @(posedge clk) disable iff (!rst_sync_n_q)
    1'b1 |=> lane_drive_q[0].eq_level == $past(eq_q[1][3:0]) &&
      lane_drive_q[1].eq_level == $past(eq_q[2][3:0]) &&
      lane_drive_q[2].eq_level == $past(eq_q[3][3:0]))
    else $error("data lane eq level does not follow its register");

  emph_zero_a: assert property (
    @(posedge clk) disable iff (!rst_sync_n_q)
    es_q[3][6:4] == 3'h0 |=> lane_drive_q[2].emph_db10 == 8'sh00)
    else $error("lane2 emphasis code 0 not 0.0 dB");

  emph_max_a: assert property (
    @(posedge clk) disable iff (!rst_sync_n_q)
    es_q[2][6:4] == 3'h2 |=> lane_drive_q[1].emph_db10 == 8'sh3C)
    else $error("lane1 emphasis code 2 not 6.0 dB");

  emph_neg_a: assert property (
    @(posedge clk) disable iff (!rst_sync_n_q)
    es_q[2][6:4] == 3'h4 |=> lane_drive_q[1].emph_db10 == -8'sh0F)
    else $error("lane1 emphasis code 4 not -1.5 dB");

  limited_pct_a: assert property (
    @(posedge clk) disable iff (!rst_sync_n_q)
    (!linear_mode && es_q[3][2:0] == 3'h1) |=> lane_drive_q[2].swing_pct == -6'sh0A)
    else $error("limited swing code 1 not minus 10 percent");

  swing_nominal_a: assert property (
    @(posedge clk) disable iff (!rst_sync_n_q)
    (!linear_mode && es_q[1][2:0] == 3'h3) |=> lane_drive_q[0].swing_mv == 11'h3E8)
    else $error("limited swing code 3 not 1000 mV");

  swing_max_a: assert property (
    @(posedge clk) disable iff (!rst_sync_n_q)
    (!linear_mode && es_q[3][2:0] == 3'h7) |=> lane_drive_q[2].swing_mv == 11'h4B0)
    else $error("limited swing code 7 not 1200 mV");

  linear_min_a: assert property (
    @(posedge clk) disable iff (!rst_sync_n_q)
    (linear_mode && es_q[3][2:0] == 3'h0) |=> lane_drive_q[2].swing_mv == 11'h320)
    else $error("linear swing code 0 not 800 mV");

  linear_mid_a: assert property (
    @(posedge clk) disable iff (!rst_sync_n_q)
    (linear_mode && es_q[3][2:0] == 3'h1) |=> lane_drive_q[2].swing_mv == 11'h384)
    else $error("linear swing code 1 not 900 mV");

  linear_rsvd_a: assert property (
    @(posedge clk) disable iff (!rst_sync_n_q)
    (linear_mode && es_q[3][2]) |=> lane_drive_q[2].code_reserved)
    else $error("reserved linear swing code not flagged");

  linear_pct_a: assert property (
    @(posedge clk) disable iff (!rst_sync_n_q)
    linear_mode |=> lane_drive_q[0].swing_pct == 6'sh00 &&
      lane_drive_q[1].swing_pct == 6'sh00 &&
      lane_drive_q[2].swing_pct == 6'sh00)
    else $error("percent trim applied in linear mode");

  eq_write_a: assert property (
    @(posedge clk) disable iff (!rst_sync_n_q)
    (wr_en && addr == lsec_pkg::LANE0_EQUALIZER_OFS) |=> eq_q[1] == ($past(wr_data) & 8'h0F))
    else $error("lane0 eq write not masked");

  es_write_a: assert property (
    @(posedge clk) disable iff (!rst_sync_n_q)
    (wr_en && addr == lsec_pkg::LANE2_EMPHASIS_SWING_OFS) |=> es_q[3] == ($past(wr_data) & 8'h77))
    else $error("lane2 emphasis swing write not masked");

  eq_mask_a: assert property (
    @(posedge clk) disable iff (!rst_sync_n_q)
    ((eq_q[0] | eq_q[1] | eq_q[2] | eq_q[3]) & 8'hF0) == 8'h00)
    else $error("reserved eq register bit set");

  es_mask_a: assert property (
    @(posedge clk) disable iff (!rst_sync_n_q)
    ((es_q[0] | es_q[1] | es_q[2] | es_q[3]) & 8'h88) == 8'h00)
    else $error("reserved emphasis swing register bit set");

  unmapped_read_a: assert property (
    @(posedge clk) disable iff (!rst_sync_n_q)
    (rd_en && !rdec.hit) |=> rd_data_q == 8'h00)
    else $error("unmapped read not zero");

  es_read_a: assert property (
    @(posedge clk) disable iff (!rst_sync_n_q)
    (rd_en && addr == lsec_pkg::LANE1_EMPHASIS_SWING_OFS) |=> rd_data_q == $past(es_q[2]))
    else $error("lane1 emphasis swing read mismatch");

  eq_read_a: assert property (
    @(posedge clk) disable iff (!rst_sync_n_q)
    (rd_en && addr == lsec_pkg::CLOCK_LANE_EQUALIZER_OFS) |=> rd_data_q == $past(eq_q[0]))
    else $error("clock lane eq read mismatch");
endmodule : lsec_config_bank

/* hdl/lsec_lane_decode.sv */
// Decoder from one lane's register codes to analog drive values
`timescale 1ns/1ns
module lsec_lane_decode (
  input wire lsec_pkg::lsec_lane_cfg_s cfg, // Register codes of the lane
  input wire logic linear_mode, // High for linear redriver operation
  output lsec_pkg::lsec_lane_drive_s drive // Decoded drive values
);
  always_comb begin
    drive.eq_level = cfg.eq_level;
    drive.emph_db10 = lsec_pkg::EMPH_DB10[cfg.emphasis];
    drive.swing_pct = lsec_pkg::LIMITED_PCT[cfg.swing];
    drive.code_reserved = (cfg.emphasis == lsec_pkg::EMPH_RESERVED_CODE);
    if (linear_mode) begin
      drive.swing_pct = '0;
      if (cfg.swing <= lsec_pkg::SWING_LINEAR_MAX_CODE) begin
        drive.swing_mv = lsec_pkg::LINEAR_MV[cfg.swing[1:0]];
      end else begin
        // Reserved linear codes hold the nominal swing and are flagged
        drive.swing_mv = lsec_pkg::LIMITED_NOMINAL_MV;
        drive.code_reserved = 1'b1;
      end
    end else begin
      drive.swing_mv = 11'(lsec_pkg::LIMITED_NOMINAL_MV
        + 11'($signed(lsec_pkg::LIMITED_PCT[cfg.swing]) * $signed(lsec_pkg::MV_PER_PCT)));
    end
  end
endmodule : lsec_lane_decode

/* hdl/lsec_pkg.sv */
// Package with offsets, field layouts, reset values and decode tables of the lane config bank
package lsec_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int LANES = 3;

  // Register offsets (byte addresses on the management port)
  localparam logic [7:0] CLOCK_LANE_EMPHASIS_OFS = 8'h12;
  localparam logic [7:0] CLOCK_LANE_EQUALIZER_OFS = 8'h13;
  localparam logic [7:0] LANE0_EMPHASIS_SWING_OFS = 8'h14;
  localparam logic [7:0] LANE0_EQUALIZER_OFS = 8'h15;
  localparam logic [7:0] LANE1_EMPHASIS_SWING_OFS = 8'h16;
  localparam logic [7:0] LANE1_EQUALIZER_OFS = 8'h17;
  localparam logic [7:0] LANE2_EMPHASIS_SWING_OFS = 8'h18;
  localparam logic [7:0] LANE2_EQUALIZER_OFS = 8'h19;

  // Field positions
  localparam int EQ_LSB = 0;
  localparam int EQ_W = 4;
  localparam int EMPH_LSB = 4;
  localparam int EMPH_W = 3;
  localparam int SWING_LSB = 0;
  localparam int SWING_W = 3;

  // Writable bit masks; all other bits are reserved and read zero
  localparam logic [7:0] EQ_MASK = 8'h0F;
  localparam logic [7:0] EMPH_SWING_MASK = 8'h77;

  // Reset values
  localparam logic [7:0] EQ_RESET = 8'h00;
  localparam logic [7:0] EMPH_SWING_RESET = 8'h03;

  // Encodings
  localparam logic [2:0] EMPH_RESERVED_CODE = 3'h3;
  localparam logic [2:0] SWING_NOMINAL_CODE = 3'h3;
  localparam logic [2:0] SWING_LINEAR_MAX_CODE = 3'h3;

  // Emphasis in tenths of a dB, per code
  localparam logic signed [7:0] EMPH_DB10 [8] = '{
    8'sh00, 8'sh23, 8'sh3C, 8'sh00, -8'sh0F, -8'sh19, -8'sh23, -8'sh30};
  // Limited-redriver swing trim in percent, per code
  localparam logic signed [5:0] LIMITED_PCT [8] = '{
    -6'sh0F, -6'sh0A, -6'sh05, 6'sh00, 6'sh05, 6'sh0A, 6'sh0F, 6'sh14};
  localparam logic [10:0] LIMITED_NOMINAL_MV = 11'h3E8;
  localparam logic [10:0] MV_PER_PCT = 11'h00A;
  // Linear-redriver swing in mV, per code 0..3
  localparam logic [10:0] LINEAR_MV [4] = '{11'h320, 11'h384, 11'h3E8, 11'h4B0};

  typedef struct packed {
    logic [3:0] eq_level;
    logic [2:0] emphasis;
    logic [2:0] swing;
  } lsec_lane_cfg_s;

  typedef struct packed {
    logic [3:0] eq_level;
    logic signed [7:0] emph_db10;
    logic signed [5:0] swing_pct;
    logic [10:0] swing_mv;
    logic code_reserved;
  } lsec_lane_drive_s;

  typedef struct packed {
    logic hit;
    logic is_eq;
    logic [1:0] idx;
  } lsec_decode_s;
endpackage : lsec_pkg

/* sim/testbench.sv */
// Self-checking testbench of the lane equalizer, emphasis and swing register bank
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic hdmi21_mode = 1'b0;
  logic linear_mode = 1'b0;
  logic [7:0] rd_data_q;
  logic [3:0] clock_lane_eq_level_q;
  logic signed [7:0] clock_lane_emphasis_q;
  lsec_pkg::lsec_lane_drive_s [2:0] lane_drive_q;
  int error_cnt = 0;
  int checked = 0;
  int edb[8] = '{0, 35, 60, 0, -15, -25, -35, -48};
  int pct[8] = '{-15, -10, -5, 0, 5, 10, 15, 20};
  int lmv[8] = '{800, 900, 1000, 1200, 1000, 1000, 1000, 1000};

  always #2 clk = ~clk;

  lsec_config_bank i_lsec_config_bank (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .hdmi21_mode(hdmi21_mode), .linear_mode(linear_mode),
    .rd_data_q(rd_data_q), .clock_lane_eq_level_q(clock_lane_eq_level_q),
    .clock_lane_emphasis_q(clock_lane_emphasis_q), .lane_drive_q(lane_drive_q)
  );

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : do_reset

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    check("rd_data_q", 16'(rd_data_q), 16'(exp));
  endtask : rd

  // Drive outputs follow a register or mode change one cycle later
  task automatic set_mode(input logic h, input logic l);
    @(posedge clk);
    hdmi21_mode <= h;
    linear_mode <= l;
    repeat (2) @(posedge clk);
    #1;
  endtask : set_mode

  task automatic reset_values();
    for (int a = 8'h12; a <= 8'h19; a++) begin
      rd(8'(a), a[0] ? 8'h00 : 8'h03);
    end
    rd(8'h1A, 8'h00);
  endtask : reset_values

  task automatic reserved_bits();
    for (int a = 8'h12; a <= 8'h19; a++) begin
      wr(8'(a), 8'hFF);
      rd(8'(a), a[0] ? 8'h0F : 8'h77);
    end
    wr(8'h1A, 8'hFF);
    rd(8'h1A, 8'h00);
  endtask : reserved_bits

  task automatic emphasis_table();
    for (int i = 0; i < 8; i++) begin
      wr(8'h16, {1'b0, 3'(i), 4'h3});
      set_mode(1'b0, 1'b0);
      check("emph_db10", 16'(lane_drive_q[1].emph_db10), 16'(edb[i]));
      check("code_reserved", 16'(lane_drive_q[1].code_reserved), 16'(i == 3));
    end
  endtask : emphasis_table

  task automatic swing_tables();
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 8; i++) begin
        wr(8'h18, {5'h00, 3'(i)});
        set_mode(1'b0, m[0]);
        check("swing_mv", 16'(lane_drive_q[2].swing_mv),
              16'(m ? lmv[i] : 1000 + pct[i] * 10));
        check("swing_pct", 16'(lane_drive_q[2].swing_pct), 16'(m ? 0 : pct[i]));
        check("swing_rsv", 16'(lane_drive_q[2].code_reserved), 16'(m && i > 3));
      end
    end
  endtask : swing_tables

  task automatic clock_lane_and_eq();
    wr(8'h13, 8'h0A);
    wr(8'h12, 8'h10);
    wr(8'h15, 8'h0F);
    wr(8'h17, 8'h00);
    wr(8'h19, 8'h05);
    set_mode(1'b0, 1'b0);
    check("clock_eq_off", 16'(clock_lane_eq_level_q), 16'h0000);
    check("clk_emph_off", 16'(clock_lane_emphasis_q), 16'h0000);
    check("lane0_eq", 16'(lane_drive_q[0].eq_level), 16'h000F);
    check("lane1_eq", 16'(lane_drive_q[1].eq_level), 16'h0000);
    check("lane2_eq", 16'(lane_drive_q[2].eq_level), 16'h0005);
    set_mode(1'b1, 1'b0);
    check("clock_eq_on", 16'(clock_lane_eq_level_q), 16'h000A);
    check("clk_emph_on", 16'(clock_lane_emphasis_q), 16'(35));
    set_mode(1'b0, 1'b1);
    check("clock_eq_drop", 16'(clock_lane_eq_level_q), 16'h0000);
    check("clk_emph_drop", 16'(clock_lane_emphasis_q), 16'h0000);
  endtask : clock_lane_and_eq

  // Write then read on the next cycle, strobes back to back
  task automatic back_to_back();
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= 8'h15;
    wr_data <= 8'hA9;
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    check("b2b_rd_data", 16'(rd_data_q), 16'h0009);
  endtask : back_to_back

  initial begin
    do_reset();
    reset_values();
    reserved_bits();
    emphasis_table();
    swing_tables();
    clock_lane_and_eq();
    back_to_back();
    do_reset();
    reset_values();
    tally_and_finish();
  end

  initial begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end
endmodule : testbench
